/* rtl/swsr_map.vh */
// Constants shared by the single-wire identity slave
`ifndef SWSR_MAP_VH
`define SWSR_MAP_VH

// Core clock rate in MHz
`define SWSR_CLK_MHZ 250
// Timer width, big enough for the longest count
`define SWSR_TMR_W 17

// Low time taken as a bus reset; between the 120 us and 480 us marks
`define SWSR_RESET_DETECT_US 300
// Master reset low time, least
`define SWSR_RESET_LOW_US 480
// Wait after the reset rising edge before presence, 15 to 60 us
`define SWSR_PRESENCE_WAIT_US 30
// Presence pulse length, 60 to 240 us
`define SWSR_PRESENCE_LOW_US 120
// Write slot sample point: past a one (under 15), before a zero ends (60)
`define SWSR_WRITE_SAMPLE_US 30
// Read slot hold of a zero; master samples within 15 us
`define SWSR_READ_HOLD_US 30
// Read data valid window seen by the master
`define SWSR_READ_VALID_US 15

// Identity commands
`define SWSR_CMD_READ 8'h33
`define SWSR_CMD_MATCH 8'h55
`define SWSR_CMD_SEARCH 8'hf0
`define SWSR_CMD_SKIP 8'hcc

// Check byte polynomial x^8+x^5+x^4+1, bit-reversed for LSB-first shifting
`define SWSR_CRC_POLY 8'h8c

// Identity fields; values are arbitrary
`define SWSR_FAMILY_CODE 8'h5a
`define SWSR_SERIAL_NUM 48'h0123_4567_89ab

// Received-data buffer
`define SWSR_FIFO_WIDTH 8
`define SWSR_FIFO_DEPTH 8
`define SWSR_FIFO_AW 3

`endif

/* rtl/swsr_slave.v */
// Single-wire identity slave: line timing, identity commands, data FIFO
`timescale 1ns/100ps
`default_nettype none
`include "swsr_map.vh"

// Byte FIFO with a registered output stage
module swsr_fifo #(
   parameter WIDTH = `SWSR_FIFO_WIDTH,
   parameter DEPTH = `SWSR_FIFO_DEPTH,
   parameter AW = `SWSR_FIFO_AW
) (
   input wire clk_i,               // Core clock
   input wire reset_n_i,           // Async reset, active low
   input wire in_valid_i,          // Write request
   output wire in_ready_o,         // Room for a word
   input wire [WIDTH-1:0] in_data_i, // Write data
   output reg out_valid_o,         // Output word present
   input wire out_ready_i,         // Consumer takes the word
   output reg [WIDTH-1:0] out_data_o // Output word
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;
   wire [AW:0] depth_w;

   assign depth_w = DEPTH[AW:0];
   assign in_ready_o = (cnt_r != depth_w);
   assign push = in_valid_i & in_ready_o;
   // The output stage refills only from stored words
   assign pop = (cnt_r != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

   always @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         out_valid_o <= 1'b0;
         out_data_o <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            out_data_o <= mem_r[rp_r];
            out_valid_o <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// Functional notes
// - A long low line never causes a power-on reset of this slave.
// - Order: initialization, one identity command, then a function.
// - Initialization is master reset pulse then slave presence pulse.
// - After presence the master sends one eight-bit identity command.
// - Command 33h sends family code, serial number, then check byte.
// - Command 55h compares 64 bits; mismatch goes silent until reset.
// - Command F0h per bit: send bit, send complement, read master bit.
// - Command CCh enables the function layer immediately.
// - Slave only pulls low through open drain; results wire-AND.
// - Master starts every slot; slave starts only the presence pulse.
// - Slave waits 15-60 us after reset edge, then pulls 60-240 us.
// - Each slot's falling edge starts the slave's internal delay.
// - Write slots sampled after the delay; one is short, zero long.
// - Read zero holds the line for the delay; read one never pulls.
// - All bytes and identity bits travel least significant bit first.
// - Identity is family byte, 48-bit serial, then check byte.
// - Check byte uses x^8+x^5+x^4+1 from zero; whole code leaves zero.
module swsr_slave #(
   parameter [7:0] FAMILY_CODE = `SWSR_FAMILY_CODE,   // Arbitrary value
   parameter [47:0] SERIAL_NUM = `SWSR_SERIAL_NUM,    // Arbitrary value
   parameter [`SWSR_TMR_W-1:0] RESET_DETECT_CYC =
      `SWSR_RESET_DETECT_US * `SWSR_CLK_MHZ,
   parameter [`SWSR_TMR_W-1:0] PRESENCE_WAIT_CYC =
      `SWSR_PRESENCE_WAIT_US * `SWSR_CLK_MHZ,
   parameter [`SWSR_TMR_W-1:0] PRESENCE_LOW_CYC =
      `SWSR_PRESENCE_LOW_US * `SWSR_CLK_MHZ,
   parameter [`SWSR_TMR_W-1:0] WRITE_SAMPLE_CYC =
      `SWSR_WRITE_SAMPLE_US * `SWSR_CLK_MHZ,
   parameter [`SWSR_TMR_W-1:0] READ_HOLD_CYC =
      `SWSR_READ_HOLD_US * `SWSR_CLK_MHZ
) (
   input wire clk_i,             // Core clock, 250 MHz
   input wire reset_n_i,         // Async reset, active low
   input wire dq_i,              // Data line level
   output reg dq_o,              // Data line drive value, always low
   output reg dq_oe_n_o,         // Drive enable, low pulls the line
   output wire sel_o,            // Function layer enabled
   output reg bus_reset_o,       // Pulse when a bus reset is taken
   output wire rx_valid_o,       // Received function byte present
   output wire [7:0] rx_data_o,  // Received function byte
   input wire rx_ready_i         // Consumer takes the byte
);
   localparam TW = `SWSR_TMR_W;

   // Line states
   localparam [4:0] LN_IDLE = 5'h01;
   localparam [4:0] LN_SLOT = 5'h02;
   localparam [4:0] LN_REC = 5'h04;
   localparam [4:0] LN_PWAIT = 5'h08;
   localparam [4:0] LN_PLOW = 5'h10;

   // Protocol states
   localparam [5:0] PS_CMD = 6'h01;
   localparam [5:0] PS_READ = 6'h02;
   localparam [5:0] PS_MATCH = 6'h04;
   localparam [5:0] PS_SRCH = 6'h08;
   localparam [5:0] PS_QUIET = 6'h10;
   localparam [5:0] PS_FUNC = 6'h20;

   function [7:0] crc_of;
      input [55:0] d;
      integer i;
      reg [7:0] c;
      begin
         c = 8'h00;
         for (i = 0; i < 56; i = i + 1) begin
            if (c[0] ^ d[i]) begin
               c = (c >> 1) ^ `SWSR_CRC_POLY;
            end else begin
               c = c >> 1;
            end
         end
         crc_of = c;
      end
   endfunction

   localparam [55:0] ID_BODY = {SERIAL_NUM, FAMILY_CODE};
   localparam [63:0] ID_CODE = {crc_of(ID_BODY), ID_BODY};

   reg [4:0] ln_r;
   reg [5:0] ps_r;
   reg dq_r;
   reg [TW-1:0] tmr_r;
   reg [TW-1:0] low_r;
   reg rst_pend_r;
   reg [5:0] idx_r;
   reg [1:0] step_r;
   reg [7:0] sh_r;
   reg [2:0] bcnt_r;
   reg hold_v_r;
   reg [7:0] hold_d_r;

   wire fall;
   wire rise;
   wire id_bit;
   wire tx_mode;
   wire tx_bit;
   wire [7:0] cmd_full;
   wire in_ready;
   wire last_idx;

   assign fall = dq_r & ~dq_i;
   assign rise = ~dq_r & dq_i;
   assign id_bit = ID_CODE[idx_r];
   assign last_idx = (idx_r == 6'h3f);
   assign tx_mode = (ps_r == PS_READ) |
      ((ps_r == PS_SRCH) & (step_r != 2'h2));
   // Search sends the bit, then its complement
   assign tx_bit = (ps_r == PS_SRCH && step_r == 2'h1) ? ~id_bit : id_bit;
   assign cmd_full = {dq_i, sh_r[7:1]};
   assign sel_o = ps_r[5];

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ln_r <= LN_IDLE;
         ps_r <= PS_QUIET;
         dq_r <= 1'b1;
         dq_o <= 1'b0;
         dq_oe_n_o <= 1'b1;
         bus_reset_o <= 1'b0;
         tmr_r <= {TW{1'b0}};
         low_r <= {TW{1'b0}};
         rst_pend_r <= 1'b0;
         idx_r <= 6'h00;
         step_r <= 2'h0;
         sh_r <= 8'h00;
         bcnt_r <= 3'h0;
         hold_v_r <= 1'b0;
         hold_d_r <= 8'h00;
      end else begin
         dq_r <= dq_i;
         bus_reset_o <= 1'b0;
         if (hold_v_r & in_ready) begin
            hold_v_r <= 1'b0;
         end
         // Only a bus reset restarts the slave; a long low is not power loss
         if (dq_i) begin
            low_r <= {TW{1'b0}};
         end else if (low_r != RESET_DETECT_CYC) begin
            low_r <= low_r + {{(TW-1){1'b0}}, 1'b1};
         end else begin
            rst_pend_r <= 1'b1;
         end
         if (rise & rst_pend_r) begin
            // Abort whatever was in progress and answer with presence
            rst_pend_r <= 1'b0;
            ln_r <= LN_PWAIT;
            ps_r <= PS_CMD;
            tmr_r <= {TW{1'b0}};
            idx_r <= 6'h00;
            step_r <= 2'h0;
            bcnt_r <= 3'h0;
            dq_oe_n_o <= 1'b1;
            bus_reset_o <= 1'b1;
         end else begin
            case (ln_r)
               LN_IDLE: begin
                  // Only the master's falling edge opens a slot
                  if (fall && ps_r != PS_QUIET) begin
                     ln_r <= LN_SLOT;
                     tmr_r <= {TW{1'b0}};
                     if (tx_mode & ~tx_bit) begin
                        dq_oe_n_o <= 1'b0;
                     end
                  end
               end
               LN_SLOT: begin
                  tmr_r <= tmr_r + {{(TW-1){1'b0}}, 1'b1};
                  if (tx_mode && tmr_r == READ_HOLD_CYC) begin
                     dq_oe_n_o <= 1'b1;
                     ln_r <= LN_REC;
                     if (ps_r == PS_READ) begin
                        idx_r <= idx_r + 6'h01;
                        if (last_idx) begin
                           ps_r <= PS_FUNC;
                        end
                     end else begin
                        step_r <= step_r + 2'h1;
                     end
                  end else if (!tx_mode && tmr_r == WRITE_SAMPLE_CYC) begin
                     ln_r <= LN_REC;
                     case (ps_r)
                        PS_CMD: begin
                           sh_r <= cmd_full;
                           bcnt_r <= bcnt_r + 3'h1;
                           if (bcnt_r == 3'h7) begin
                              idx_r <= 6'h00;
                              step_r <= 2'h0;
                              case (cmd_full)
                                 `SWSR_CMD_READ: begin
                                    ps_r <= PS_READ;
                                 end
                                 `SWSR_CMD_MATCH: begin
                                    ps_r <= PS_MATCH;
                                 end
                                 `SWSR_CMD_SEARCH: begin
                                    ps_r <= PS_SRCH;
                                 end
                                 `SWSR_CMD_SKIP: begin
                                    ps_r <= PS_FUNC;
                                 end
                                 default: begin
                                    ps_r <= PS_QUIET;
                                 end
                              endcase
                           end
                        end
                        PS_MATCH: begin
                           idx_r <= idx_r + 6'h01;
                           if (dq_i != id_bit) begin
                              ps_r <= PS_QUIET;
                           end else if (last_idx) begin
                              ps_r <= PS_FUNC;
                           end
                        end
                        PS_SRCH: begin
                           idx_r <= idx_r + 6'h01;
                           step_r <= 2'h0;
                           if (dq_i != id_bit) begin
                              ps_r <= PS_QUIET;
                           end else if (last_idx) begin
                              ps_r <= PS_FUNC;
                           end
                        end
                        PS_FUNC: begin
                           // A full buffer stalls assembly; bits meanwhile drop
                           if (!hold_v_r) begin
                              sh_r <= cmd_full;
                              bcnt_r <= bcnt_r + 3'h1;
                              if (bcnt_r == 3'h7) begin
                                 hold_v_r <= 1'b1;
                                 hold_d_r <= cmd_full;
                              end
                           end
                        end
                        default: begin
                           ln_r <= LN_REC;
                        end
                     endcase
                  end
               end
               LN_REC: begin
                  // Next slot needs the line back high first
                  if (dq_i) begin
                     ln_r <= LN_IDLE;
                  end
               end
               LN_PWAIT: begin
                  tmr_r <= tmr_r + {{(TW-1){1'b0}}, 1'b1};
                  if (tmr_r == PRESENCE_WAIT_CYC - 1'b1) begin
                     ln_r <= LN_PLOW;
                     tmr_r <= {TW{1'b0}};
                     dq_oe_n_o <= 1'b0;
                  end
               end
               LN_PLOW: begin
                  tmr_r <= tmr_r + {{(TW-1){1'b0}}, 1'b1};
                  if (tmr_r == PRESENCE_LOW_CYC - 1'b1) begin
                     ln_r <= LN_REC;
                     dq_oe_n_o <= 1'b1;
                  end
               end
               default: begin
                  ln_r <= LN_IDLE;
                  dq_oe_n_o <= 1'b1;
               end
            endcase
         end
      end
   end

   swsr_fifo #(
      .WIDTH(8),
      .DEPTH(`SWSR_FIFO_DEPTH),
      .AW(`SWSR_FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(hold_v_r),
      .in_ready_o(in_ready),
      .in_data_i(hold_d_r),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(rx_data_o)
   );
endmodule
`default_nettype wire

/* verification/swsr_slave_checker.sv */
// Port assertions for the single-wire identity slave
`timescale 1ns/100ps
`default_nettype none
module swsr_slave_checker #(
   parameter int RESET_DETECT_CYC = 300,
   parameter int PRESENCE_WAIT_CYC = 60,
   parameter int PRESENCE_LOW_CYC = 200,
   parameter int READ_HOLD_CYC = 60
) (
   input wire logic clk_i,            // Clock
   input wire logic reset_n_i,        // Reset, low
   input wire logic dq_i,             // Line level
   input wire logic dq_o,             // Drive value
   input wire logic dq_oe_n_o,        // Pull enable
   input wire logic sel_o,            // Selected
   input wire logic bus_reset_o,      // Bus reset pulse
   input wire logic rx_valid_o,       // Byte present
   input wire logic [7:0] rx_data_o,  // Byte
   input wire logic rx_ready_i        // Byte taken
);
   localparam int PW_LO = PRESENCE_WAIT_CYC - 9;
   localparam int PW_HI = PRESENCE_WAIT_CYC - 5;
   localparam int PL_LO = PRESENCE_LOW_CYC - 1;
   localparam int PL_HI = PRESENCE_LOW_CYC + 1;
   localparam int RH_LO = READ_HOLD_CYC;
   localparam int RH_HI = READ_HOLD_CYC + 2;
   int lo_run_r;
   int last_run_r;
   int oe_low_r;
   logic pres_r;

   // Run lengths of the line and of our own pull, for timing checks
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lo_run_r <= 0;
         last_run_r <= 0;
         oe_low_r <= 0;
         pres_r <= 1'b0;
      end else begin
         lo_run_r <= dq_i ? 0 : lo_run_r + 1;
         if (dq_i && lo_run_r != 0) last_run_r <= lo_run_r;
         oe_low_r <= dq_oe_n_o ? 0 : oe_low_r + 1;
         if (bus_reset_o) pres_r <= 1'b1;
         else if (dq_oe_n_o && oe_low_r != 0) pres_r <= 1'b0;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_quiet;
      dq_oe_n_o [*8];
   endsequence
   sequence s_pull;
      $fell(dq_oe_n_o);
   endsequence

   a_drive_low_only: assert property (dq_o == 1'b0)
      else $error("slave drove the line high");
   a_presence_wait: assert property (
      bus_reset_o |-> s_quiet ##[PW_LO:PW_HI] s_pull)
      else $error("presence start out of window");
   a_presence_len: assert property (
      $rose(dq_oe_n_o) && pres_r |-> oe_low_r inside {[PL_LO:PL_HI]})
      else $error("presence length wrong");
   a_read_hold: assert property (
      $rose(dq_oe_n_o) && !pres_r |-> oe_low_r inside {[RH_LO:RH_HI]})
      else $error("read zero hold wrong");
   a_read_start: assert property (
      $fell(dq_oe_n_o) && !pres_r |-> !$past(dq_i) && $past(dq_i, 3))
      else $error("pull not started by a slot edge");
   a_reset_cause: assert property (
      bus_reset_o |-> last_run_r > RESET_DETECT_CYC)
      else $error("bus reset without long low");
   a_reset_taken: assert property (
      $rose(dq_i) && lo_run_r > RESET_DETECT_CYC |-> ##[0:2] bus_reset_o)
      else $error("long low not taken as bus reset");
   a_bus_deselect: assert property (bus_reset_o |-> ##1 !sel_o)
      else $error("still selected after bus reset");
   a_rx_hold: assert property (
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("received byte not held");
endmodule

bind swsr_slave swsr_slave_checker #(
   .RESET_DETECT_CYC(RESET_DETECT_CYC),
   .PRESENCE_WAIT_CYC(PRESENCE_WAIT_CYC),
   .PRESENCE_LOW_CYC(PRESENCE_LOW_CYC),
   .READ_HOLD_CYC(READ_HOLD_CYC)
) u_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .dq_i(dq_i), .dq_o(dq_o),
   .dq_oe_n_o(dq_oe_n_o), .sel_o(sel_o), .bus_reset_o(bus_reset_o),
   .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
   .rx_ready_i(rx_ready_i));
`default_nettype wire

/* verification/swsr_master.sv */
// Bus master model on the open-drain data line
`timescale 1ns/100ps
`default_nettype none
module swsr_master (
   input wire logic clk_i,       // Clock
   input wire logic slv_oe_n_i,  // Slave pull, low
   input wire logic slv_dq_i,    // Slave drive value
   output wire logic line_o      // Resolved line
);
   logic rel_r = 1'b1;
   // Pull-up wins only where nobody pulls low
   assign line_o = rel_r & (slv_oe_n_i | slv_dq_i);

   task automatic hold(input int n, input logic v);
      rel_r <= v;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bus_reset(output logic seen);
      seen = 1'b0;
      hold(400, 1'b0);
      rel_r <= 1'b1;
      repeat (400) begin
         @(posedge clk_i);
         if (line_o === 1'b0) seen = 1'b1;
      end
   endtask
   task automatic write_bit(input logic b);
      hold(b ? 8 : 100, 1'b0);
      hold(b ? 112 : 20, 1'b1);
   endtask
   task automatic read_bit(output logic b);
      hold(2, 1'b0);
      hold(12, 1'b1);
      b = line_o;
      hold(106, 1'b1);
   endtask
endmodule
`default_nettype wire

/* verification/single_wire_slave_rom_layer_test.sv */
// Self-checking bench for the single-wire identity slave
`timescale 1ns/100ps
`default_nettype none
module single_wire_slave_rom_layer_test;
   localparam logic [7:0] FAM = 8'h3c;  // Arbitrary value
   localparam logic [47:0] SER = 48'h0a1b_2c3d_4e5f;  // Arbitrary value
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic rx_ready_i = 1'b0;
   logic hold_rx = 1'b1;
   wire dq, dq_o, oe_n, sel_o, bus_reset_o, rx_valid_o;
   wire [7:0] rx_data_o;
   int failures = 0;
   int checked = 0;
   integer seed = 32'hdddbe186;
   logic [63:0] rom;
   logic [7:0] exp_q[$];

   swsr_slave #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER),
      .RESET_DETECT_CYC(300), .PRESENCE_WAIT_CYC(60),
      .PRESENCE_LOW_CYC(200), .WRITE_SAMPLE_CYC(60),
      .READ_HOLD_CYC(60)) uut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .dq_i(dq), .dq_o(dq_o),
      .dq_oe_n_o(oe_n), .sel_o(sel_o), .bus_reset_o(bus_reset_o),
      .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
      .rx_ready_i(rx_ready_i));
   swsr_master m (.clk_i(clk_i), .slv_oe_n_i(oe_n), .slv_dq_i(dq_o),
      .line_o(dq));

   initial forever #2 clk_i = ~clk_i;

   task automatic check(input string what, input logic [63:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
      logic [7:0] c = 8'h00;
      for (int i = 0; i < n; i++)
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
      return c;
   endfunction
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) m.write_bit(b[i]);
   endtask
   task automatic rd(input int n, output logic [63:0] v);
      logic b;
      v = '0;
      for (int i = 0; i < n; i++) begin
         m.read_bit(b);
         v[i] = b;
      end
   endtask
   task automatic start(input logic [7:0] cmd);
      logic p;
      m.bus_reset(p);
      check("presence", p, 1);
      check("deselect", sel_o, 0);
      send(cmd);
   endtask

   always @(posedge clk_i) begin
      rx_ready_i <= hold_rx ? 1'b0 : 1'($random(seed));
      if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
         // An unexpected byte is compared against unknown and fails
         if (exp_q.size() == 0) exp_q.push_back('x);
         check("rx byte", rx_data_o, exp_q.pop_front());
      end
   end

   initial begin
      logic [63:0] v;
      logic [7:0] cmds [7];
      logic b;
      cmds = '{8'h33, 8'h55, 8'hf0, 8'hcc, 8'ha5, 8'h55, 8'hf0};
      rom = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      hold_rx <= 1'b0;
      @(posedge clk_i);
      m.read_bit(b);
      check("quiet line", b, 1);
      for (int k = 0; k < 7; k++) begin
         start(cmds[k]);
         case (k)
            0: begin
               rd(64, v);
               check("rom read", v, rom);
               check("rom crc", crc8(v, 64), 0);
            end
            1, 5: for (int i = 0; i < 64; i++)
               m.write_bit(rom[i] ^ (k == 5 && i == 63));
            2, 6: for (int i = 0; i < (k == 6 ? 5 : 64); i++) begin
               rd(2, v);
               check("search pair", v[1:0],
                  (k == 6 && i == 4) ? 2'b11 : {~rom[i], rom[i]});
               m.write_bit(rom[i] ^ (k == 6 && i == 3));
            end
            default: ;
         endcase
         check("select", sel_o, k < 4);
         if (k < 4) begin
            v[7:0] = $random(seed);
            exp_q.push_back(v[7:0]);
            send(v[7:0]);
         end else begin
            m.read_bit(b);
            check("silent", b, 1);
         end
         $display("command test %0d done", k);
      end
      // Abort a read-out part way, then restart with skip
      start(8'h33);
      rd(10, v);
      check("part read", v[9:0], rom[9:0]);
      start(8'hcc);
      check("restart sel", sel_o, 1);
      $display("abort test done");
      hold_rx <= 1'b1;
      repeat (9) begin
         v[7:0] = $random(seed);
         exp_q.push_back(v[7:0]);
         send(v[7:0]);
      end
      check("full valid", rx_valid_o, 1);
      hold_rx <= 1'b0;
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk_i);
      check("drained", exp_q.size(), 0);
      $display("buffer test done");
      report_and_stop;
   end
endmodule
`default_nettype wire
